// ---- src/pbn_pkg.sv ----
// Purpose: shared constants for the pended bus node controller
// Assumes: one bus cycle per mclk_in period; bus fields sampled as plain synchronous inputs
// Notes:   confirmation code is taken high-true after the bus receivers
//
// Summary of operation
// - I/O node sends interrupt request; processor acknowledges; I/O returns vector.
// - first acknowledge wins; others seeing it clear pending interrupt for that device.
// - arbitration overlaps transfers; granted node transfers in the following cycle.
// - keep-bus line grants the current transmitter the next cycle regardless of requests.
// - bad parity in a later cycle of multi-cycle transfer aborts the transaction.
// - launch bus signals in first phase, capture in second; cycle spans phase one.
// - function codes: 000 noop, 001 command, 010 write data, 011 response, 10n, 11n.
// - read data sequence bit 0 for data cycles 0 and 2, 1 for 1 and 3.
// - 64 payload lines carry command, address, mask or 64 data bits.
// - source identifier carries commander id on command and returned data cycles.
// - grant asserted same cycle as request, captured at cycle end to enable drivers.
// - even parity over 64 data, 3 function and 5 identifier bits.
package pbn_pkg;
	localparam int unsigned DATA_W = 64;
	localparam int unsigned FN_W   = 3;
	localparam int unsigned ID_W   = 5;
	localparam int unsigned CNF_W  = 5;
	localparam int unsigned SLOT_W = 4;
	localparam int unsigned NODES  = 16;

	// cycle function codes
	localparam logic [2:0] FN_NOOP = 3'h0;
	localparam logic [2:0] FN_CMD  = 3'h1;
	localparam logic [2:0] FN_WDAT = 3'h2;
	localparam logic [2:0] FN_NDR  = 3'h3;
	localparam logic [1:0] FN_GRD_HI = 2'h2;
	localparam logic [1:0] FN_CRD_HI = 2'h3;

	// command field values
	localparam logic [3:0] CMD_READ   = 4'h1;
	localparam logic [3:0] CMD_IREAD  = 4'h2;
	localparam logic [3:0] CMD_TAGBAD = 4'h5;
	localparam logic [3:0] CMD_UWRITE = 4'h6;
	localparam logic [3:0] CMD_WRITE  = 4'h7;
	localparam logic [3:0] CMD_INTR   = 4'h8;
	localparam logic [3:0] CMD_IDENT  = 4'h9;
	localparam logic [3:0] CMD_PROCESSOR_TO_PROCESSOR_INTERRUPT = 4'hF;

	// field positions inside the payload lines
	localparam int unsigned CMDF_LO  = 60;
	localparam int unsigned MASK_LO  = 32;
	localparam int unsigned LVL_LO   = 16;
	localparam int unsigned TGT_LO   = 0;
	localparam int unsigned NDR_LOCK = 0;

	// processor interrupt constants
	localparam logic [3:0] IPI_LEVEL  = 4'hE;
	localparam logic [7:0] IPI_VECTOR = 8'h80;
	localparam logic [7:0] INTR_VECTOR_NONE = 8'h00;

	// decoded confirmation values
	localparam logic [1:0] CNF_NACK = 2'h0;
	localparam logic [1:0] CNF_ACK  = 2'h1;
	localparam logic [1:0] CNF_BUSY = 2'h2;
	localparam logic [1:0] CNF_DEF  = 2'h3;

	// error codes reported to the user
	localparam logic [2:0] ERR_TIMEOUT = 3'h1;
	localparam logic [2:0] ERR_BUSY    = 3'h2;
	localparam logic [2:0] ERR_LOCK    = 3'h3;
	localparam logic [2:0] ERR_ABORT   = 3'h4;
	localparam logic [2:0] ERR_CNF     = 3'h5;

	// timing
	localparam int unsigned CLK_NS       = 100;
	localparam int unsigned BUS_MIN_NS   = 80;
	localparam int unsigned BUS_MAX_NS   = 320;
	localparam int unsigned TIMEOUT_US   = 1000;
	localparam int unsigned TIMEOUT_CYC  = TIMEOUT_US * 1000 / CLK_NS;
	localparam int unsigned BUSY_TRIES   = 8;
	localparam int unsigned LOCK_TRIES   = 8;
	localparam int unsigned BACKOFF_CYC  = 16;

	function automatic logic bus_par(input logic [63:0] d, input logic [2:0] f,
		input logic [4:0] i);
		bus_par = ^{d, f, i};
	endfunction

	// returns {uncorrectable, code}
	function automatic logic [2:0] cnf_fix(input logic [4:0] c);
		logic t1;
		logic t2;
		logic t3;
		t1 = c[2] ^ c[0];
		t2 = c[3] ^ c[1];
		t3 = c[4] ^ c[1] ^ c[0];
		if (t1 && t2) begin
			cnf_fix = {1'b1, c[1:0]};
		end else if (!t3) begin
			cnf_fix = {1'b0, c[1:0]};
		end else begin
			cnf_fix = {1'b0, c[3:2]};
		end
	endfunction
endpackage

// ---- src/pbn_tbl_if.sv ----
`timescale 1ns/1ns
// Purpose: link between node controller and its pending-interrupt table
// Assumes: single clock
// Notes:   read data returns one cycle after the address
interface pbn_tbl_if;
	logic       wr_en;
	logic [3:0] wr_addr;
	logic [4:0] wr_data;
	logic [3:0] rd_addr;
	logic [4:0] rd_data;
	modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
		input rd_data);
	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
		output rd_data);
endinterface

// ---- src/pbn_pend_tbl.sv ----
`timescale 1ns/1ns
// Purpose: pending-interrupt table, one entry per source slot
// Assumes: entry = {pending, level[3:0]}
// Notes:   registered read; entries cleared at reset
module pbn_pend_tbl
	import pbn_pkg::*;
#(
	parameter int unsigned DEPTH = NODES
) (
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	pbn_tbl_if.store  tbl
);
	logic [4:0] mem_r [DEPTH];

	// ****************************************
	// storage
	// ****************************************
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem_r[k] <= 5'h00;
			end
		end else if (tbl.wr_en) begin
			mem_r[tbl.wr_addr] <= tbl.wr_data;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tbl.rd_data <= 5'h00;
		end else begin
			tbl.rd_data <= mem_r[tbl.rd_addr];
		end
	end
endmodule

// ---- src/pbn_node.sv ----
`timescale 1ns/1ns
// Purpose: processor-side bus node: commander engine plus bus monitor
// Assumes: one bus cycle per mclk_in; arbiter is external
// Notes:   one transaction at a time, id select bit chosen per command
module pbn_node
	import pbn_pkg::*;
#(
	parameter int unsigned TO_CYC   = TIMEOUT_CYC,
	parameter int unsigned BUSY_MAX = BUSY_TRIES,
	parameter int unsigned LOCK_MAX = LOCK_TRIES,
	parameter int unsigned BACK_CYC = BACKOFF_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic [3:0]  slot_id_in,
	// arbitration
	output logic             cmd_req_out,
	input  wire logic        grant_in,
	input  wire logic        hold_in,
	output logic             hold_out,
	output logic             hold_oe_out,
	// bus fields
	input  wire logic [2:0]  bus_fn_in,
	input  wire logic [4:0]  bus_id_in,
	input  wire logic [63:0] bus_data_in,
	input  wire logic        bus_par_in,
	output logic [2:0]       bus_fn_out,
	output logic [4:0]       bus_id_out,
	output logic [63:0]      bus_data_out,
	output logic             bus_par_out,
	output logic             bus_oe_out,
	input  wire logic [4:0]  conf_in,
	input  wire logic        pfault_in,
	output logic             pfault_out,
	output logic             pfault_oe_out,
	// user command side
	input  wire logic        cmd_valid_in,
	output logic             cmd_ready_out,
	input  wire logic [63:0] cmd_word_in,
	input  wire logic        cmd_sel_in,
	input  wire logic [1:0]  wbeats_in,
	input  wire logic [1:0]  rbeats_in,
	input  wire logic [63:0] wdata_in,
	output logic             wdata_take_out,
	output logic             done_out,
	output logic             release_out,
	output logic             err_out,
	output logic [2:0]       err_code_out,
	output logic             rdata_valid_out,
	output logic [63:0]      rdata_out,
	output logic             rdata_seq_out,
	output logic             rdata_corr_out,
	// received interrupt events
	output logic             ev_valid_out,
	input  wire logic        ev_ready_in,
	output logic [3:0]       ev_level_out,
	output logic [7:0]       ev_vector_out,
	output logic [3:0]       ev_src_out
);
	localparam int unsigned TO_W = $clog2(TO_CYC + 1);
	localparam int unsigned BK_W = $clog2(BACK_CYC + 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARB  = 3'b001,
		ST_CMD  = 3'b010,
		ST_WDAT = 3'b011,
		ST_CONF = 3'b100,
		ST_RESP = 3'b101,
		ST_BACK = 3'b110
	} pbn_state_t;

	pbn_state_t  st_r;
	pbn_state_t  st_nxt;
	logic [63:0] cmd_word_r;
	logic        cmd_sel_r;
	logic [1:0]  wbeats_r;
	logic [1:0]  rbeats_r;
	logic [1:0]  wcnt_r;
	logic [1:0]  rcnt_r;
	logic        rgot_r;
	logic [1:0]  cmd_sr_r;
	logic [1:0]  wd_sr_r;
	logic [2:0]  cnf_r;
	logic        cnf_pf_r;
	logic        wd_bad_r;
	logic [3:0]  busy_cnt_r;
	logic [3:0]  lock_cnt_r;
	logic [BK_W-1:0] back_r;
	logic [TO_W-1:0] to_r;
	logic        arb_seen_r;
	// capture registers for the second phase
	logic [2:0]  rx_fn_r;
	logic [4:0]  rx_id_r;
	logic [63:0] rx_data_r;
	logic        rx_bad_r;
	logic        rx_valid_r;

	logic [3:0]  cmd_code;
	logic [4:0]  my_id;
	logic        is_read;
	logic        rx_ok;
	logic        rx_mine;
	logic        rx_cmd;
	logic        rx_to_me;
	logic        rx_rdata;
	logic        timeout;
	logic        fin_done;
	logic        fin_rel;
	logic        fin_err;
	logic [2:0]  fin_code;
	logic        hold_drv;

	pbn_tbl_if tbl ();

	pbn_pend_tbl #(.DEPTH(NODES)) u_tbl (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.tbl       (tbl.store)
	);

	// ****************************************
	// decode
	// ****************************************
	assign cmd_code = cmd_word_r[CMDF_LO +: 4];
	assign my_id    = {slot_id_in, cmd_sel_r};
	assign is_read  = (cmd_code == CMD_READ) || (cmd_code == CMD_IREAD)
		|| (cmd_code == CMD_IDENT);
	assign rx_ok    = rx_valid_r && !rx_bad_r;
	assign rx_cmd   = rx_ok && (rx_fn_r == FN_CMD);
	assign rx_to_me = rx_data_r[MASK_LO + slot_id_in];
	assign rx_mine  = rx_ok && (rx_id_r == my_id);
	assign rx_rdata = rx_mine && rx_fn_r[2];
	assign timeout  = (to_r == TO_W'(TO_CYC - 1));
	assign cmd_ready_out = (st_r == ST_IDLE);
	assign hold_out    = hold_drv || (ev_valid_out && !ev_ready_in);
	assign hold_oe_out = hold_out;
	assign wdata_take_out = (st_nxt == ST_WDAT);

	// ****************************************
	// next state and completion
	// ****************************************
	always_comb begin
		st_nxt   = st_r;
		fin_done = 1'b0;
		fin_rel  = 1'b0;
		fin_err  = 1'b0;
		fin_code = ERR_ABORT;
		case (st_r)
			ST_IDLE: begin
				if (cmd_valid_in) begin
					st_nxt = ST_ARB;
				end
			end
			ST_ARB: begin
				if (cmd_code == CMD_IDENT && arb_seen_r && !tbl.rd_data[4]) begin
					fin_rel = 1'b1;
					st_nxt  = ST_IDLE;
				end else if (grant_in) begin
					st_nxt = ST_CMD;
				end
			end
			ST_CMD: begin
				st_nxt = (wbeats_r != 2'h0) ? ST_WDAT : ST_CONF;
			end
			ST_WDAT: begin
				if (wcnt_r == wbeats_r) begin
					st_nxt = ST_CONF;
				end
			end
			ST_CONF: begin
				if (cmd_sr_r == 2'h0 && wd_sr_r == 2'h0) begin
					if (wd_bad_r || cnf_pf_r) begin
						fin_err = 1'b1;
						st_nxt  = ST_IDLE;
					end else if (cnf_r[2]) begin
						fin_err  = 1'b1;
						fin_code = ERR_CNF;
						st_nxt   = ST_IDLE;
					end else if (cnf_r[1:0] == CNF_BUSY) begin
						if (busy_cnt_r == 4'(BUSY_MAX - 1)) begin
							fin_err  = 1'b1;
							fin_code = ERR_BUSY;
							st_nxt   = ST_IDLE;
						end else begin
							st_nxt = ST_ARB;
						end
					end else if (cnf_r[1:0] == CNF_NACK) begin
						fin_err = 1'b1;
						st_nxt  = ST_IDLE;
					end else if (cnf_r[1:0] == CNF_DEF || is_read) begin
						st_nxt = ST_RESP;
					end else begin
						fin_done = 1'b1;
						st_nxt   = ST_IDLE;
					end
				end
			end
			ST_RESP: begin
				if (rx_valid_r && rx_bad_r && rgot_r) begin
					fin_err = 1'b1;
					st_nxt  = ST_IDLE;
				end else if (rx_mine && rx_fn_r == FN_NDR) begin
					if (cmd_code == CMD_IREAD && rx_data_r[NDR_LOCK]) begin
						if (lock_cnt_r == 4'(LOCK_MAX - 1)) begin
							fin_err  = 1'b1;
							fin_code = ERR_LOCK;
							st_nxt   = ST_IDLE;
						end else begin
							st_nxt = ST_BACK;
						end
					end else begin
						fin_done = 1'b1;
						st_nxt   = ST_IDLE;
					end
				end else if (rx_rdata && rcnt_r == rbeats_r) begin
					fin_done = 1'b1;
					st_nxt   = ST_IDLE;
				end
			end
			ST_BACK: begin
				// unlock write ends the wait early
				if (back_r == BK_W'(0) || (rx_cmd && rx_data_r[CMDF_LO +: 4] == CMD_UWRITE)) begin
					st_nxt = ST_ARB;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		if (st_r != ST_IDLE && timeout) begin
			st_nxt   = ST_IDLE;
			fin_done = 1'b0;
			fin_rel  = 1'b0;
			fin_err  = 1'b1;
			fin_code = ERR_TIMEOUT;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// command capture and counters
	// ****************************************
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_word_r <= 64'h0;
			cmd_sel_r  <= 1'b0;
			wbeats_r   <= 2'h0;
			rbeats_r   <= 2'h0;
		end else if (st_r == ST_IDLE && cmd_valid_in) begin
			cmd_word_r <= cmd_word_in;
			cmd_sel_r  <= cmd_sel_in;
			wbeats_r   <= wbeats_in;
			rbeats_r   <= rbeats_in;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			to_r       <= '0;
			busy_cnt_r <= 4'h0;
			lock_cnt_r <= 4'h0;
			back_r     <= '0;
			arb_seen_r <= 1'b0;
		end else begin
			// counted in bus cycles, so the 1000 us limit holds only at the CLK_NS clock period
			to_r       <= (st_nxt == ST_IDLE) ? '0 : to_r + TO_W'(1);
			arb_seen_r <= (st_r == ST_ARB) && (st_nxt == ST_ARB);
			if (st_r == ST_IDLE) begin
				busy_cnt_r <= 4'h0;
				lock_cnt_r <= 4'h0;
			end else if (st_r == ST_CONF && st_nxt == ST_ARB) begin
				busy_cnt_r <= busy_cnt_r + 4'h1;
			end else if (st_nxt == ST_BACK && st_r == ST_RESP) begin
				lock_cnt_r <= lock_cnt_r + 4'h1;
			end
			back_r <= (st_r == ST_BACK) ? back_r - BK_W'(1) : BK_W'(BACK_CYC);
		end
	end

	// ****************************************
	// bus drive
	// ****************************************
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus_fn_out   <= FN_NOOP;
			bus_id_out   <= 5'h00;
			bus_data_out <= 64'h0;
			bus_par_out  <= 1'b0;
			bus_oe_out   <= 1'b0;
			hold_drv     <= 1'b0;
			wcnt_r       <= 2'h0;
		end else if (st_nxt == ST_CMD) begin
			bus_fn_out   <= FN_CMD;
			bus_id_out   <= my_id;
			bus_data_out <= cmd_word_r;
			bus_par_out  <= bus_par(cmd_word_r, FN_CMD, my_id);
			bus_oe_out   <= 1'b1;
			// keep the bus for write data
			hold_drv     <= (wbeats_r != 2'h0);
			wcnt_r       <= 2'h0;
		end else if (st_nxt == ST_WDAT) begin
			bus_fn_out   <= FN_WDAT;
			bus_id_out   <= my_id;
			bus_data_out <= wdata_in;
			bus_par_out  <= bus_par(wdata_in, FN_WDAT, my_id);
			bus_oe_out   <= 1'b1;
			hold_drv     <= (wcnt_r + 2'h2 <= wbeats_r);
			wcnt_r       <= wcnt_r + 2'h1;
		end else begin
			// undriven bus reads as noop with good parity
			bus_fn_out   <= FN_NOOP;
			bus_id_out   <= 5'h00;
			bus_data_out <= 64'h0;
			bus_par_out  <= 1'b0;
			bus_oe_out   <= 1'b0;
			hold_drv     <= 1'b0;
		end
	end

	assign cmd_req_out = (st_r == ST_ARB);

	// ****************************************
	// confirmation tracking, two cycles behind
	// ****************************************
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_sr_r <= 2'h0;
			wd_sr_r  <= 2'h0;
			cnf_r    <= 3'h0;
			cnf_pf_r <= 1'b0;
			wd_bad_r <= 1'b0;
		end else begin
			cmd_sr_r <= {cmd_sr_r[0], st_r == ST_CMD};
			wd_sr_r  <= {wd_sr_r[0], st_r == ST_WDAT};
			if (st_r == ST_CMD) begin
				wd_bad_r <= 1'b0;
			end else if (wd_sr_r[1] && (pfault_in || cnf_fix(conf_in) != {1'b0, CNF_ACK})) begin
				wd_bad_r <= 1'b1;
			end
			if (cmd_sr_r[1]) begin
				cnf_r    <= cnf_fix(conf_in);
				cnf_pf_r <= pfault_in;
			end
		end
	end

	// ****************************************
	// receive capture and parity check
	// ****************************************
	// capture every cycle before use
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_fn_r    <= FN_NOOP;
			rx_id_r    <= 5'h00;
			rx_data_r  <= 64'h0;
			rx_bad_r   <= 1'b0;
			rx_valid_r <= 1'b0;
		end else begin
			rx_fn_r    <= bus_fn_in;
			rx_id_r    <= bus_id_in;
			rx_data_r  <= bus_data_in;
			rx_bad_r   <= bus_par(bus_data_in, bus_fn_in, bus_id_in) != bus_par_in;
			rx_valid_r <= 1'b1;
		end
	end

	// fault lands in the confirmation slot
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pfault_out <= 1'b0;
		end else begin
			pfault_out <= rx_valid_r && rx_bad_r;
		end
	end
	assign pfault_oe_out = pfault_out;

	// ****************************************
	// pending interrupt table upkeep
	// ****************************************
	always_comb begin
		tbl.wr_en   = 1'b0;
		tbl.wr_addr = rx_id_r[4:1];
		tbl.wr_data = 5'h00;
		tbl.rd_addr = cmd_word_r[TGT_LO +: 4];
		if (rx_cmd && rx_data_r[CMDF_LO +: 4] == CMD_INTR && rx_to_me) begin
			// remember the request and its level
			tbl.wr_en   = 1'b1;
			tbl.wr_data = {1'b1, rx_data_r[LVL_LO +: 4]};
		end else if (rx_cmd && rx_data_r[CMDF_LO +: 4] == CMD_IDENT) begin
			tbl.wr_en   = 1'b1;
			tbl.wr_addr = rx_data_r[TGT_LO +: 4];
		end
	end

	// ****************************************
	// user results and events
	// ****************************************
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			done_out        <= 1'b0;
			release_out     <= 1'b0;
			err_out         <= 1'b0;
			err_code_out    <= 3'h0;
			rdata_valid_out <= 1'b0;
			rdata_out       <= 64'h0;
			rdata_seq_out   <= 1'b0;
			rdata_corr_out  <= 1'b0;
			rcnt_r          <= 2'h0;
			rgot_r          <= 1'b0;
		end else begin
			done_out        <= fin_done;
			release_out     <= fin_rel;
			err_out         <= fin_err;
			err_code_out    <= fin_err ? fin_code : 3'h0;
			rdata_valid_out <= 1'b0;
			if (st_r != ST_RESP) begin
				rcnt_r <= 2'h0;
				rgot_r <= 1'b0;
			end else if (rx_rdata) begin
				rdata_valid_out <= 1'b1;
				rdata_out       <= rx_data_r;
				rdata_seq_out   <= rx_fn_r[0];
				rdata_corr_out  <= (rx_fn_r[2:1] == FN_CRD_HI);
				rcnt_r          <= rcnt_r + 2'h1;
				rgot_r          <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ev_valid_out  <= 1'b0;
			ev_level_out  <= 4'h0;
			ev_vector_out <= 8'h00;
			ev_src_out    <= 4'h0;
		end else if (rx_cmd && rx_to_me && rx_data_r[CMDF_LO +: 4] == CMD_PROCESSOR_TO_PROCESSOR_INTERRUPT) begin
			ev_valid_out  <= 1'b1;
			ev_level_out  <= IPI_LEVEL;
			ev_vector_out <= IPI_VECTOR;
			ev_src_out    <= rx_id_r[4:1];
		end else if (rx_cmd && rx_to_me && rx_data_r[CMDF_LO +: 4] == CMD_INTR) begin
			ev_valid_out  <= 1'b1;
			ev_level_out  <= rx_data_r[LVL_LO +: 4];
			ev_vector_out <= INTR_VECTOR_NONE;
			ev_src_out    <= rx_id_r[4:1];
		end else if (ev_ready_in) begin
			ev_valid_out <= 1'b0;
		end
	end
endmodule

// ---- sim/pbn_far.sv ----
`timescale 1ns/1ns
// Purpose: far side of the node, arbiter grant and responder confirmation
// Assumes: one bus cycle per clock
// Notes:   the bench picks the confirmation code; no drive reads as nack
module pbn_far (
	input  wire logic       mclk_in,
	input  wire logic       resetn_in,
	input  wire logic       req_in,
	input  wire logic       oe_in,
	input  wire logic       gnt_en_in,
	input  wire logic [1:0] cnf_in,
	output logic            gnt_out,
	output logic [4:0]      conf_out
);
	// ****
	// grant and confirmation
	// ****
	logic [1:0] oe_r;
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			oe_r <= 2'h0;
		end else begin
			oe_r <= {oe_r[0], oe_in};
		end
	end
	assign gnt_out = req_in && gnt_en_in;
	assign conf_out = oe_r[1] ? {cnf_in[1] ^ cnf_in[0], cnf_in, cnf_in} : 5'h00;
endmodule

// ---- sim/pbn_node_props.sv ----
`timescale 1ns/1ns
// Purpose: protocol checks on the node ports
// Assumes: one clock, reset active low
// Notes:   attached by bind below
module pbn_node_props
	import pbn_pkg::*;
(
	input wire logic        mclk_in, resetn_in, cmd_req_out, grant_in, hold_out,
	input wire logic        bus_par_in, bus_par_out, bus_oe_out, pfault_out,
	input wire logic        rdata_valid_out, rdata_seq_out, rdata_corr_out, ev_valid_out,
	input wire logic [3:0]  slot_id_in, ev_level_out,
	input wire logic [2:0]  bus_fn_in, bus_fn_out,
	input wire logic [4:0]  bus_id_in, bus_id_out,
	input wire logic [7:0]  ev_vector_out,
	input wire logic [63:0] bus_data_in, bus_data_out
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	wire logic bad = bus_par_in ^ (^{bus_data_in, bus_fn_in, bus_id_in});
	sequence s_cmd;
		bus_oe_out && bus_fn_out == FN_CMD;
	endsequence
	sequence s_ipi;
		!bad && bus_fn_in == FN_CMD && bus_data_in[63:60] == CMD_PROCESSOR_TO_PROCESSOR_INTERRUPT
			&& bus_data_in[32 + slot_id_in];
	endsequence
	property p_gnt; cmd_req_out && grant_in |=> s_cmd; endproperty
	a_gnt: assert property (p_gnt) else $error("grant not followed by command");
	property p_idle; !bus_oe_out |-> bus_fn_out == FN_NOOP && !bus_par_out; endproperty
	a_idle: assert property (p_idle) else $error("idle bus not noop");
	property p_par; bus_oe_out |-> !(^{bus_par_out, bus_data_out, bus_fn_out, bus_id_out});
	endproperty
	a_par: assert property (p_par) else $error("driven parity odd");
	property p_id; s_cmd |-> bus_id_out[4:1] == slot_id_in; endproperty
	a_id: assert property (p_id) else $error("command id wrong");
	property p_hold; s_cmd ##1 bus_oe_out |-> $past(hold_out) && bus_fn_out == FN_WDAT;
	endproperty
	a_hold: assert property (p_hold) else $error("extra cycle without keep-bus");
	property p_pf; bad |-> ##2 pfault_out; endproperty
	a_pf: assert property (p_pf) else $error("parity fault not flagged");
	property p_ipi; s_ipi |-> ##2 ev_valid_out && ev_level_out == IPI_LEVEL
		&& ev_vector_out == IPI_VECTOR; endproperty
	a_ipi: assert property (p_ipi) else $error("processor interrupt event wrong");
	property p_rd; rdata_valid_out |-> rdata_seq_out == $past(bus_fn_in[0], 2)
		&& rdata_corr_out == $past(bus_fn_in[1], 2); endproperty
	a_rd: assert property (p_rd) else $error("read beat flags wrong");
endmodule
bind pbn_node pbn_node_props chk (.*);

// ---- sim/pbn_node_tb.sv ----
`timescale 1ns/1ns
// Purpose: self-checking bench for the bus node
// Assumes: bus lines looped back, far side in pbn_far
// Notes:   short limits keep the run brief
module pbn_node_tb;
	import pbn_pkg::*;
	// ****
	// bench
	// ****
	localparam logic [4:0] MYID = 5'h0B;
	logic mclk_in, resetn_in, cmd_req_out, grant_in, hold_out, hold_oe_out, bus_par_out;
	logic bus_oe_out, pfault_out, pfault_oe_out, cmd_valid_in, cmd_ready_out, cmd_sel_in;
	logic wdata_take_out, done_out, release_out, err_out, rdata_valid_out, rdata_seq_out;
	logic rdata_corr_out, ev_valid_out, ev_ready_in, gnt_en, bad;
	logic [1:0] cnf, wbeats_in, rbeats_in;
	logic [2:0] bus_fn_out, err_code_out, ifn;
	logic [3:0] slot_id_in, ev_level_out, ev_src_out;
	logic [4:0] bus_id_out, conf_in, iid;
	logic [7:0] ev_vector_out;
	logic [63:0] bus_data_out, cmd_word_in, wdata_in, rdata_out, idat;
	logic [65:0] rq[$];
	int err_count, tests_run;
	wire logic hold_in = hold_out;
	wire logic pfault_in = pfault_out;
	wire logic [2:0] bus_fn_in = bus_oe_out ? bus_fn_out : ifn;
	wire logic [4:0] bus_id_in = bus_oe_out ? bus_id_out : iid;
	wire logic [63:0] bus_data_in = bus_oe_out ? bus_data_out : idat;
	wire logic bus_par_in = bus_oe_out ? bus_par_out : bad ^ (^{idat, ifn, iid});
	pbn_node #(.TO_CYC(64), .BUSY_MAX(2), .LOCK_MAX(2), .BACK_CYC(4)) uut (.*);
	pbn_far far (.mclk_in, .resetn_in, .req_in(cmd_req_out), .oe_in(bus_oe_out),
		.gnt_en_in(gnt_en), .cnf_in(cnf), .gnt_out(grant_in), .conf_out(conf_in));
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	always @(negedge mclk_in) if (rdata_valid_out === 1'b1) begin
		rq.push_back({rdata_corr_out, rdata_seq_out, rdata_out});
	end
	task chk(input logic [65:0] g, input logic [65:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task put(input logic [2:0] f, input logic [63:0] d, input logic b);
		@(negedge mclk_in);
		{ifn, iid, idat, bad} = {f, MYID, d, b};
		@(negedge mclk_in);
		{ifn, iid, idat, bad} = '0;
	endtask
	task go(input logic [3:0] c, input logic [1:0] wb, input logic [1:0] rb);
		int n;
		@(negedge mclk_in);
		{cmd_word_in, wbeats_in, rbeats_in} = {c, 12'h0, 16'h00FF, 32'h1000, wb, rb};
		cmd_valid_in = 1'b1;
		@(negedge mclk_in);
		cmd_valid_in = 1'b0;
		for (n = 0; n < 8 && bus_oe_out !== 1'b1; n++) tick(1);
	endtask
	task fin(input logic [2:0] ec);
		int n;
		for (n = 0; n < 300 && done_out !== 1'b1 && err_out !== 1'b1; n++) tick(1);
		chk(err_out, ec != 3'h0);
		chk(err_code_out & {3{err_out}}, ec);
	endtask
	task t_write;
		go(CMD_WRITE, 2'h1, 2'h0);
		chk({bus_fn_out, bus_id_out, hold_out}, {FN_CMD, MYID, 1'b1});
		chk({wdata_take_out, hold_oe_out, cmd_ready_out}, 3'b110);
		tick(1);
		chk(bus_fn_out, FN_WDAT);
		chk({bus_data_out, hold_out}, {wdata_in, 1'b0});
		fin(3'h0);
	endtask
	task t_read;
		rq.delete();
		go(CMD_READ, 2'h0, 2'h1);
		tick(5);
		put(3'b100, 64'h1111_2222_3333_4444, 1'b0);
		put(3'b111, 64'h5555_6666_7777_8888, 1'b0);
		fin(3'h0);
		// last beat is collected on this same edge
		tick(1);
		chk(rq.size(), 2);
		chk(rq[0], {2'b00, 64'h1111_2222_3333_4444});
		chk(rq[1], {2'b11, 64'h5555_6666_7777_8888});
	endtask
	task t_retry;
		cnf = CNF_BUSY;
		go(CMD_READ, 2'h0, 2'h0);
		fin(ERR_BUSY);
		cnf = CNF_ACK;
		gnt_en = 1'b0;
		go(CMD_READ, 2'h0, 2'h0);
		chk(bus_oe_out, 1'b0);
		fin(ERR_TIMEOUT);
		gnt_en = 1'b1;
	endtask
	task t_lock;
		int n;
		go(CMD_IREAD, 2'h0, 2'h0);
		repeat (2) begin
			for (n = 0; n < 40 && bus_oe_out !== 1'b1; n++) tick(1);
			tick(2);
			put(FN_NDR, 64'h1, 1'b0);
		end
		fin(ERR_LOCK);
	endtask
	task t_intr;
		int n;
		put(FN_CMD, {CMD_INTR, 12'h0, 16'h0020, 12'h0, 4'h9, 16'h0}, 1'b0);
		for (n = 0; n < 8 && ev_valid_out !== 1'b1; n++) tick(1);
		chk({ev_level_out, ev_vector_out, ev_src_out}, {4'h9, INTR_VECTOR_NONE, 4'h5});
		ev_ready_in = 1'b1;
		gnt_en = 1'b0;
		cmd_word_in = {CMD_IDENT, 56'h0, 4'h5};
		cmd_valid_in = 1'b1;
		tick(1);
		{ev_ready_in, cmd_valid_in} = '0;
		tick(4);
		chk({release_out, cmd_ready_out}, 2'b00);
		put(FN_CMD, {CMD_IDENT, 56'h0, 4'h5}, 1'b0);
		for (n = 0; n < 8 && release_out !== 1'b1; n++) tick(1);
		chk({release_out, err_out, cmd_ready_out}, 3'b101);
		gnt_en = 1'b1;
	endtask
	task t_ipi;
		int n;
		put(FN_CMD, {CMD_PROCESSOR_TO_PROCESSOR_INTERRUPT, 12'h0, 16'h0020, 32'h0}, 1'b0);
		for (n = 0; n < 8 && ev_valid_out !== 1'b1; n++) tick(1);
		chk({ev_level_out, ev_vector_out, hold_out}, {IPI_LEVEL, IPI_VECTOR, 1'b1});
		chk({ev_src_out, hold_oe_out}, {4'h5, 1'b1});
		ev_ready_in = 1'b1;
		tick(1);
		ev_ready_in = 1'b0;
	endtask
	task t_par;
		int k;
		k = 0;
		put(FN_NOOP, 64'h0, 1'b1);
		repeat (4) begin
			k += (pfault_out === 1'b1 && pfault_oe_out === 1'b1);
			tick(1);
		end
		chk(k, 1);
	endtask
	task test_done;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		{resetn_in, cmd_valid_in, cmd_word_in, wbeats_in, rbeats_in, ev_ready_in} = '0;
		{ifn, iid, idat, bad, err_count, tests_run} = '0;
		{slot_id_in, cmd_sel_in, gnt_en, cnf} = {4'h5, 1'b1, 1'b1, CNF_ACK};
		wdata_in = 64'h0123_4567_89AB_CDEF;
		repeat (4) @(posedge mclk_in);
		tick(1);
		resetn_in = 1'b1;
		t_write;
		t_read;
		t_retry;
		t_lock;
		t_ipi;
		t_intr;
		t_par;
		test_done;
	end
	// run is far shorter than this cap
	initial begin
		#1000000;
		err_count++;
		test_done;
	end
endmodule
